// [asc_pkg.sv]
/*
 * Constants shared by the scan sequencer, its checker, the converter core model and the bench.
 * Assumes one 100 MHz system clock and config fields held by an outer register file.
 */
package asc_pkg;
    // ****************************************
    // Channel layout
    // ****************************************
    localparam int NCH = 16;
    localparam logic [15:0] SCAN_IMPL_ALL = 16'hFFFF;
    localparam logic [15:0] SCAN_NONE = 16'h0000;
    localparam logic [3:0] CH_OFFSET = 4'hF;
    localparam logic [3:0] CH_COMMON = 4'hE;
    localparam logic [3:0] CH_SUPPLY = 4'hD;
    localparam logic [3:0] CH_TEMP = 4'hC;
    localparam logic [3:0] CH_DIFF_LO = 4'h8;
    localparam logic [3:0] SE_LOW_NIBBLE = 4'h8;
    localparam logic [7:0] SEL_OFFSET = 8'h88;
    localparam logic [7:0] SEL_COMMON = 8'hF8;
    localparam logic [7:0] SEL_SUPPLY = 8'h98;
    localparam logic [7:0] SEL_TEMP = 8'hDE;
    // Offset of the selector register, ignored while scanning
    localparam logic [3:0] INPUT_SELECTOR_OFFSET = 4'h6;
    // ****************************************
    // Field codes
    // ****************************************
    localparam logic [2:0] GAIN_THIRD = 3'h0;
    localparam logic [2:0] GAIN_ONE = 3'h3;
    localparam logic [1:0] PWR_SHUTDOWN = 2'h0;
    localparam logic [1:0] PWR_STANDBY = 2'h2;
    localparam logic [1:0] PWR_CONVERT = 2'h3;
    localparam logic [1:0] REPEAT_LOOP = 2'h3;
    localparam logic [1:0] FMT_TAGGED = 2'h3;
    localparam int DATA_W = 24;
    localparam int TAG_W = 4;
    localparam int RES_W = DATA_W + TAG_W;
    localparam int TIMER_W = 24;
    localparam int FIFO_DEPTH = 16;
    // ****************************************
    // Sequencer states, Gray along the path
    // ****************************************
    typedef enum logic [2:0] {
        ASC_IDLE = 3'h0,
        ASC_START = 3'h1,
        ASC_WAIT = 3'h3,
        ASC_PUSH = 3'h2,
        ASC_TIMER = 3'h6
    } asc_state_type;
endpackage

// [asc_stream_if.sv]
/*
 * Valid/ready word carrier between the sequencer and its result FIFO.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/10ps
interface asc_stream_if #(parameter int W = 28);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// [asc_fifo.sv]
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
module asc_fifo #(
    parameter int W = 28,
    parameter int DEPTH = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    asc_stream_if.snk wr,
    asc_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } asc_fifo_st_type;
    asc_fifo_st_type s_q, s_d;
    logic [W-1:0] mem [DEPTH];
    logic full, empty, do_wr, do_rd;

    // Extra pointer bit tells full from empty
    assign empty = (s_q.wp == s_q.rp);
    assign full = (s_q.wp[AW] != s_q.rp[AW]) && (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = mem[s_q.rp[AW-1:0]];
    assign do_wr = wr.valid && !full;
    assign do_rd = rd.ready && !empty;

    // Pointer update
    always_comb begin
        s_d = s_q;
        if (do_wr) begin
            s_d.wp = s_q.wp + 1'b1;
        end
        if (do_rd) begin
            s_d.rp = s_q.rp + 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Storage has no reset; empty flag guards stale words
    always_ff @(posedge i_clk_sys) begin
        if (do_wr) begin
            mem[s_q.wp[AW-1:0]] <= wr.data;
        end
    end
endmodule

// [asc_sequencer.sv]
/*
 * Scan sequencer of a delta-sigma converter: channel walk, overrides, result path.
 * Assumes the converter core, the host register file and the host reads
 * all run on i_clk_sys; config fields arrive as plain levels.
 */
// Contract
// - Scan conversions are always one-shot
// - One period, two with auto-zero chop
// - Repeat codes 00/01/10 run one cycle
// - Repeat 11 loops with timer between
// - Repeat field writes never reset conversion
// - Selector register ignored while scanning
// - Each completion updates result, raises ready
// - Any enable bit selects scan mode
// - Power state 11 write starts scanning
// - Power state reads 11 until done
// - Enabled channels, bit 15 down to 0
// - Tagged format puts channel index on top
// - Differential and single-ended selector codes
// - Absent channel enables are unimplemented
// - Supply channel: 0x98, forced third gain
// - Temperature channel: 0xDE, forced unity gain
// - Offset channel: 0x88, programmed gain kept
// - Common-mode channel: 0xF8, forced unity gain
// - Overrides never touch stored registers
// - Timer counts down to zero, relaunches
// - Single cycle reverts power state field
`timescale 1ns/10ps
module asc_sequencer
    import asc_pkg::*;
#(
    parameter logic [15:0] SCAN_IMPL = SCAN_IMPL_ALL,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [15:0] i_scan_enable,
    input wire logic [1:0] i_conversion_repeat_select,
    input wire logic i_auto_zero_chop_enable,
    input wire logic [1:0] i_data_format,
    input wire logic [2:0] i_gain,
    input wire logic [7:0] i_input_selector,
    input wire logic [TIMER_W-1:0] i_timer,
    input wire logic i_power_wr,
    input wire logic [1:0] i_power_val,
    input wire logic i_conv_done,
    input wire logic [DATA_W-1:0] i_conv_data,
    input wire logic i_result_hold,
    output logic o_conv_start,
    output logic [7:0] o_mux_code,
    output logic [2:0] o_gain_eff,
    output logic o_scan_mode,
    output logic o_busy,
    output logic [1:0] o_power_state,
    output logic [3:0] o_channel,
    output logic [RES_W-1:0] o_conversion_result,
    output logic o_data_ready
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        asc_state_type st;
        logic [1:0] power;
        logic [15:0] pend;
        logic [3:0] chan;
        logic second;
        logic start;
        logic [TIMER_W-1:0] timer;
        logic [RES_W-1:0] word;
        logic [RES_W-1:0] result;
        logic drdy;
    } asc_st_type;

    asc_st_type s_q, s_d;
    logic [15:0] enables;
    logic scan_on;
    logic [3:0] next_chan;
    logic [15:0] next_pend;
    logic [7:0] scan_sel;
    logic [2:0] scan_gain;

    asc_stream_if #(.W(RES_W)) push_if ();
    asc_stream_if #(.W(RES_W)) pop_if ();

    // ****************************************
    // Helpers
    // ****************************************
    // Highest set bit wins; descending priority order
    function automatic logic [3:0] top_bit(input logic [15:0] m);
        logic [3:0] r;
        r = '0;
        for (int i = 0; i < NCH; i++) begin
            if (m[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // Selector code for a channel index
    function automatic logic [7:0] chan_sel(input logic [3:0] c);
        logic [7:0] r;
        r = {c, SE_LOW_NIBBLE};
        case (c)
            CH_OFFSET: begin
                r = SEL_OFFSET;
            end
            CH_COMMON: begin
                r = SEL_COMMON;
            end
            CH_SUPPLY: begin
                r = SEL_SUPPLY;
            end
            CH_TEMP: begin
                r = SEL_TEMP;
            end
            default: begin
                if (c >= CH_DIFF_LO) begin
                    // Pair k is inputs 2k (high nibble) and 2k+1
                    r = {1'b0, c[1:0], 1'b0, 1'b0, c[1:0], 1'b1};
                end
            end
        endcase
        return r;
    endfunction

    // Gain during a channel; programmed gain unless forced
    function automatic logic [2:0] chan_gain(input logic [3:0] c, input logic [2:0] g);
        logic [2:0] r;
        r = g;
        case (c)
            CH_SUPPLY: begin
                r = GAIN_THIRD;
            end
            CH_TEMP, CH_COMMON: begin
                r = GAIN_ONE;
            end
            default: begin
                r = g;
            end
        endcase
        return r;
    endfunction

    // Absent inputs are masked off at the enable port
    assign enables = i_scan_enable & SCAN_IMPL;
    assign scan_on = (enables != SCAN_NONE);
    assign next_chan = top_bit(s_q.pend);
    assign next_pend = s_q.pend & ~(16'h0001 << s_q.chan);
    assign scan_sel = chan_sel(s_q.chan);
    assign scan_gain = chan_gain(s_q.chan, i_gain);

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.start = 1'b0;
        s_d.drdy = 1'b0;
        case (s_q.st)
            ASC_IDLE: begin
                if (i_power_wr && i_power_val == PWR_CONVERT && scan_on) begin
                    s_d.power = PWR_CONVERT;
                    s_d.pend = enables;
                    s_d.chan = top_bit(enables);
                    s_d.st = ASC_START;
                end else if (i_power_wr) begin
                    s_d.power = i_power_val;
                end
            end
            ASC_START: begin
                // Full FIFO stalls the walk rather than losing a result
                if (push_if.ready || s_q.second) begin
                    s_d.start = 1'b1;
                    s_d.st = ASC_WAIT;
                end
            end
            ASC_WAIT: begin
                if (i_conv_done) begin
                    if (i_auto_zero_chop_enable && !s_q.second) begin
                        s_d.second = 1'b1;
                        s_d.st = ASC_START;
                    end else begin
                        s_d.second = 1'b0;
                        s_d.word = (i_data_format == FMT_TAGGED) ?
                            {s_q.chan, i_conv_data} : {4'h0, i_conv_data};
                        s_d.st = ASC_PUSH;
                    end
                end
            end
            ASC_PUSH: begin
                if (push_if.ready) begin
                    s_d.pend = next_pend;
                    if (next_pend != SCAN_NONE) begin
                        s_d.chan = top_bit(next_pend);
                        s_d.st = ASC_START;
                    end else if (i_conversion_repeat_select == REPEAT_LOOP) begin
                        s_d.timer = i_timer;
                        s_d.st = ASC_TIMER;
                    end else begin
                        // Repeat field sampled only here, never mid-conversion
                        s_d.power = i_conversion_repeat_select[1] ?
                            PWR_STANDBY : PWR_SHUTDOWN;
                        s_d.st = ASC_IDLE;
                    end
                end
            end
            ASC_TIMER: begin
                if (s_q.timer == '0) begin
                    s_d.pend = enables;
                    s_d.chan = top_bit(enables);
                    s_d.st = scan_on ? ASC_START : ASC_IDLE;
                    if (!scan_on) begin
                        s_d.power = PWR_STANDBY;
                    end
                end else begin
                    s_d.timer = s_q.timer - 1'b1;
                end
            end
            default: begin
                s_d.st = ASC_IDLE;
            end
        endcase
        // Abort or restart from the host power field
        if (s_q.st != ASC_IDLE && i_power_wr) begin
            s_d.second = 1'b0;
            if (i_power_val == PWR_CONVERT && scan_on) begin
                s_d.pend = enables;
                s_d.chan = top_bit(enables);
                s_d.st = ASC_START;
            end else begin
                s_d.power = i_power_val;
                s_d.st = ASC_IDLE;
            end
        end
        // Result register loads straight from the FIFO head
        if (pop_if.valid && !i_result_hold) begin
            s_d.result = pop_if.data;
            s_d.drdy = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            s_q <= '0;
            s_q.st <= ASC_IDLE;
            s_q.power <= PWR_SHUTDOWN;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Result buffer
    // ****************************************
    assign push_if.valid = (s_q.st == ASC_PUSH);
    assign push_if.data = s_q.word;
    assign pop_if.ready = !i_result_hold;

    asc_fifo #(.W(RES_W), .DEPTH(DEPTH)) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .wr(push_if.snk),
        .rd(pop_if.src)
    );

    // ****************************************
    // Outputs
    // ****************************************
    // Overrides are applied on the way out; stored fields stay untouched
    assign o_mux_code = scan_on ? scan_sel : i_input_selector;
    assign o_gain_eff = scan_on ? scan_gain : i_gain;
    assign o_conv_start = s_q.start;
    assign o_scan_mode = scan_on;
    assign o_busy = (s_q.st != ASC_IDLE);
    assign o_power_state = s_q.power;
    assign o_channel = s_q.chan;
    assign o_conversion_result = s_q.result;
    assign o_data_ready = s_q.drdy;
endmodule

// [asc_chk.sv]
/*
 * Port checker for the scan sequencer: selector codes, forced gains, power field.
 * Assumes the default SCAN_IMPL (all enables present) and one clock.
 */
`timescale 1ns/10ps
module asc_chk
    import asc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [15:0] i_scan_enable,
    input wire logic [2:0] i_gain,
    input wire logic [7:0] i_input_selector,
    input wire logic i_power_wr,
    input wire logic [1:0] i_power_val,
    input wire logic o_conv_start,
    input wire logic [7:0] o_mux_code,
    input wire logic [2:0] o_gain_eff,
    input wire logic o_scan_mode,
    input wire logic o_busy,
    input wire logic [1:0] o_power_state,
    input wire logic [3:0] o_channel
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // ****************************************
    // Per-channel overrides; stored gain must show through on offset and single-ended channels
    // ****************************************
    a_offset_sel:
        assert property (o_busy && o_channel == CH_OFFSET |-> o_mux_code == SEL_OFFSET
            && o_gain_eff == i_gain) else $error("offset channel selection wrong");
    a_supply_sel:
        assert property (o_busy && o_channel == CH_SUPPLY |-> o_mux_code == SEL_SUPPLY
            && o_gain_eff == GAIN_THIRD) else $error("supply channel selection wrong");
    a_temp_sel:
        assert property (o_busy && o_channel == CH_TEMP |-> o_mux_code == SEL_TEMP
            && o_gain_eff == GAIN_ONE) else $error("temperature selection wrong");
    a_common_sel:
        assert property (o_busy && o_channel == CH_COMMON |-> o_mux_code == SEL_COMMON
            && o_gain_eff == GAIN_ONE) else $error("common-mode selection wrong");
    a_single_sel:
        assert property (o_busy && o_channel < CH_DIFF_LO |-> o_mux_code ==
            {o_channel, SE_LOW_NIBBLE} && o_gain_eff == i_gain) else $error("single code");
    a_selector_pass:
        assert property (!o_scan_mode |-> o_mux_code == i_input_selector)
            else $error("selector not passed in selector mode");
    a_scan_mode_any:
        assert property (o_scan_mode == (i_scan_enable != SCAN_NONE))
            else $error("scan mode does not follow enables");
    a_start_taken:
        assert property (!o_busy && o_scan_mode && i_power_wr && i_power_val == PWR_CONVERT
            |=> o_busy && o_power_state == PWR_CONVERT) else $error("start not taken");
    a_power_holds:
        assert property (o_busy |-> o_power_state == PWR_CONVERT)
            else $error("power field left 11 while busy");
    a_start_single:
        assert property (o_conv_start |=> !o_conv_start) else $error("start not one-shot");
endmodule
bind asc_sequencer asc_chk chk (.*);

// [asc_core_model.sv]
/*
 * Converter core model: one conversion period per start, then a done pulse.
 * Assumes the sequencer never restarts it mid-period except by abort.
 */
`timescale 1ns/10ps
module asc_core_model
    import asc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic [3:0] i_lat,
    output logic o_done,
    output logic [DATA_W-1:0] o_data
);
    int cnt;
    // Period countdown; the word toggles outside a done so stale data never matches
    always @(posedge i_clk_sys) begin
        o_done <= 1'b0;
        o_data <= ~o_data;
        if (i_rst) begin
            cnt <= 0;
            o_data <= '0;
        end else if (i_start) begin
            cnt <= i_lat + 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            o_done <= 1'b1;
            o_data <= DATA_W'($urandom);
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// [tb_asc_sequencer.sv]
/*
 * Self-checking bench for the scan sequencer with a converter core model.
 * Assumes the checker is bound in and the package is compiled first.
 */
`timescale 1ns/10ps
module tb_asc_sequencer
    import asc_pkg::*;
;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic [15:0] i_scan_enable = 16'h0000;
    logic [1:0] i_conversion_repeat_select = 2'h0;
    logic i_auto_zero_chop_enable = 1'b0;
    logic [1:0] i_data_format = 2'h3;
    logic [2:0] i_gain = 3'h5;
    logic [7:0] i_input_selector = 8'h00;
    logic [TIMER_W-1:0] i_timer = 24'h000028;
    logic i_power_wr = 1'b0;
    logic [1:0] i_power_val = 2'h0;
    logic i_result_hold = 1'b0;
    logic i_conv_done, o_conv_start, o_scan_mode, o_busy, o_data_ready;
    logic [DATA_W-1:0] i_conv_data;
    logic [7:0] o_mux_code;
    logic [2:0] o_gain_eff;
    logic [1:0] o_power_state;
    logic [3:0] o_channel, lat = 4'h1, tag;
    logic [RES_W-1:0] o_conversion_result;
    logic [3:0] chq[$];
    logic [DATA_W-1:0] dq[$];
    int n_errors = 0, samples_checked = 0, n_starts = 0, s0;
    asc_sequencer dut (.*);
    asc_core_model core (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_start(o_conv_start),
        .i_lat(lat), .o_done(i_conv_done), .o_data(i_conv_data));
    always #5 i_clk_sys = ~i_clk_sys;
    // Stored selector and gain wander; scanning must ignore the selector, and the gain on forced channels only
    always @(negedge i_clk_sys) begin
        i_input_selector <= 8'($urandom);
        i_gain <= 3'($urandom);
    end
    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    function automatic logic [31:0] exp_word(input logic [3:0] t, input logic [DATA_W-1:0] d);
        return {4'h0, (i_data_format == FMT_TAGGED) ? t : 4'h0, d};
    endfunction
    task automatic queue_list(input logic [15:0] en);
        for (int b = 15; b >= 0; b--) if (en[b]) chq.push_back(4'(b));
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    task automatic power(input logic [1:0] v);
        i_power_wr = 1'b1;
        i_power_val = v;
        cyc(1);
        i_power_wr = 1'b0;
    endtask
    // Host changes the repeat field just after a data ready
    task automatic wait_idle(input logic [1:0] rep2);
        int k;
        k = 0;
        while (o_busy !== 1'b0 && k < 3000) begin
            if (o_data_ready === 1'b1) i_conversion_repeat_select = rep2;
            cyc(1);
            k++;
        end
        check(k < 3000, 1'b1);
    endtask
    task automatic settle;
        i_result_hold = 1'b0;
        wait_idle(i_conversion_repeat_select);
        cyc(24);
        check(chq.size(), 0);
    endtask
    task automatic drain;
        int k;
        k = 0;
        while (chq.size() > 0 && k < 3000) begin
            cyc(1);
            k++;
        end
        check(k < 3000, 1'b1);
    endtask
    task automatic run_once(input logic [15:0] en, input logic [1:0] rep, input logic chop,
        input logic [1:0] rep2);
        i_scan_enable = en;
        i_conversion_repeat_select = rep;
        i_auto_zero_chop_enable = chop;
        lat = 4'($urandom_range(1, 9));
        queue_list(en);
        s0 = n_starts;
        power(PWR_CONVERT);
        wait_idle(rep2);
        check(o_power_state, i_conversion_repeat_select[1] ? PWR_STANDBY : PWR_SHUTDOWN);
        check(n_starts - s0, $countones(en) << chop);
        if (i_result_hold === 1'b0) settle();
        $display("run en=%h rep=%h chop=%b done", en, rep, chop);
    endtask
    // Scoreboard: every result is read at its data ready, in scan order
    // Offset results are only reported; applying trim is the host's job
    always @(negedge i_clk_sys) begin
        if (o_conv_start === 1'b1) n_starts++;
        if (i_conv_done === 1'b1) dq.push_back(i_conv_data);
        if (o_data_ready === 1'b1) begin
            if (i_auto_zero_chop_enable) void'(dq.pop_front());
            tag = chq.pop_front();
            check(o_conversion_result, exp_word(tag, dq.pop_front()));
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h9CBED28D));
        cyc(2);
        i_rst = 1'b0;
        cyc(1);
        check(o_mux_code, i_input_selector);
        check(o_scan_mode, 1'b0);
        run_once(16'hF000, 2'h0, 1'b0, 2'h0);
        run_once(16'h0F01, 2'h1, 1'b1, 2'h1);
        run_once(16'h80FF, 2'h2, 1'b0, 2'h0);
        for (int i = 0; i < 6; i++) begin
            i_data_format = 2'($urandom);
            // Two channels at least, so the repeat field changes before its last sample
            run_once(16'($urandom) | 16'h8001, 2'($urandom_range(0, 2)), 1'($urandom),
                2'($urandom_range(0, 2)));
        end
        // Full buffer: the next conversion waits for room
        i_data_format = FMT_TAGGED;
        i_result_hold = 1'b1;
        run_once(16'hFFFF, 2'h2, 1'b0, 2'h2);
        i_scan_enable = 16'h0001;
        queue_list(16'h0001);
        s0 = n_starts;
        power(PWR_CONVERT);
        cyc(50);
        check(n_starts, s0);
        settle();
        $display("buffer stall done");
        // Looping scan, enables changed mid-cycle, timer gap, abort
        i_conversion_repeat_select = REPEAT_LOOP;
        queue_list(16'hC0F0);
        queue_list(16'h0001);
        i_scan_enable = 16'hC0F0;
        power(PWR_CONVERT);
        cyc(3);
        i_scan_enable = 16'h0001;
        drain();
        s0 = n_starts;
        cyc(36);
        check(n_starts, s0);
        cyc(12);
        check(n_starts, s0 + 1);
        check(o_power_state, PWR_CONVERT);
        queue_list(16'h0001);
        drain();
        power(PWR_SHUTDOWN);
        check(o_busy, 1'b0);
        check(o_power_state, PWR_SHUTDOWN);
        $display("loop done");
        tally_and_finish();
    end
    // Watchdog: the tests need well under 20k cycles
    initial begin
        #400000;
        n_errors++;
        tally_and_finish();
    end
endmodule
